// ### shared/vme_master_pkg.sv
// Overview of operation
// R1: Select 00 runs one 32-bit LWORD cycle.
// R2: Double mode runs two D0-D15 halves.
// R3: Single word: bit3 picks A01 and half.
// R4: Byte mode: bit3 A01, bit2 A00, lane.
// R5: Byte cycle asserts only one data strobe.
// R6: Select 11 reads IACK vector, DS0 only.
// R7: Loaded select pattern kept until rewritten.
// R8: Drive A1-A31; A0 expressed via strobes.
// R9: Bus-hold bit keeps exclusive bus ownership.
// R10: Software sets bus-hold before requesting bus.
// R11: Indicator lit while bit D6 is one.
// R12: D7 read-only; set on send, cleared by IACK.
// R13: Bits 13..8 drive modifier lines every cycle.
// R14: Any modifier output; single cycles only.
// R15: Slave answers only listed eight modifier codes.
// R16: Codes 10-1F user-defined, others reserved.
// R17: D15 drives A31, D14 drives A30.
// R18: Window offset addresses longwords, 1 GByte span.
// R19: Window access starts a master cycle.
// R20: Bit 0 write fires reset pulse; reset clears.
// R21: Request, await grant, release unless held.
package vme_master_pkg;
  localparam logic [31:0] MODE_REG_ADDR   = 32'h9000_0000;
  localparam logic [3:0]  WINDOW_BASE_NIB = 4'hB;
  localparam int          SYSRST_BIT      = 0;
  localparam int          TSEL_LSB        = 1;
  localparam int          HOLD_BIT        = 5;
  localparam int          LED_BIT         = 6;
  localparam int          IRQP_BIT        = 7;
  localparam int          AM_LSB          = 8;
  localparam int          PAGE_LO_BIT     = 14;
  localparam int          PAGE_HI_BIT     = 15;
  localparam logic [15:0] MODE_RESET      = 16'h0000;
  localparam logic [1:0]  TS_LONG         = 2'h0;
  localparam logic [1:0]  TS_WORD         = 2'h1;
  localparam logic [1:0]  TS_BYTE         = 2'h2;
  localparam logic [1:0]  TS_IACK         = 2'h3;
  // Reset one-shot width is a free choice here
  localparam int          CLK_PERIOD_NS   = 50;
  localparam int          SYSRST_PULSE_NS = 200000;
  localparam int          SYSRST_CYCLES   = (SYSRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SYSRST_CNT_W    = 12;
  localparam logic [5:0]  AM_USER_LO      = 6'h10;
  localparam logic [5:0]  AM_USER_HI      = 6'h1F;
  typedef enum {XK_LONG, XK_DOUBLE, XK_WORD, XK_BYTE, XK_IACK} xfer_kind_type;
endpackage : vme_master_pkg

// ### rtl/slave_am_decode.sv
module slave_am_decode
  import vme_master_pkg::*;
#(
  parameter bit USER_AM_EN = 1'b0
) (
  input  wire logic [5:0] am_code,
  output logic            am_hit,
  output logic            am_user,
  output logic            am_reserved
);
  always_comb begin
    am_user     = (am_code >= AM_USER_LO) && (am_code <= AM_USER_HI); // R16
    am_reserved = 1'b0;
    case (am_code)
      6'h3E, 6'h3D, 6'h3A, 6'h39, 6'h2D, 6'h29, 6'h0D, 6'h09: am_hit = 1'b1; // R15
      // Generated as master, never answered as slave
      6'h3F, 6'h3B, 6'h0F, 6'h0E, 6'h0B, 6'h0A: am_hit = 1'b0; // R15
      default: begin
        // User codes join decoding only when enabled
        am_hit      = am_user && USER_AM_EN; // R16
        am_reserved = !am_user; // R16
      end
    endcase
  end
endmodule : slave_am_decode

// ### rtl/vme_master_cycle_control.sv
module vme_master_cycle_control
  import vme_master_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        processor_reset_signal,
  input  wire logic [31:0] gbus_addr,
  input  wire logic [31:0] gbus_wdata,
  input  wire logic        gbus_strobe,
  input  wire logic        gbus_write,
  output logic      [31:0] gbus_rdata,
  output logic             gbus_ack,
  output logic             vme_bus_req,
  input  wire logic        vme_bus_grant,
  output logic             vme_bus_busy,
  output logic      [31:1] vme_addr,
  output logic      [5:0]  vme_am,
  output logic             vme_addr_oe,
  output logic             vme_as_n,
  output logic             vme_ds0_n,
  output logic             vme_ds1_n,
  output logic             vme_lword_n,
  output logic             vme_write_n,
  output logic             vme_iack_n,
  input  wire logic        vme_dtack_n,
  input  wire logic [31:0] vme_data_in,
  output logic      [31:0] vme_data_out,
  output logic      [1:0]  vme_data_oe,
  input  wire logic        irq_sent,
  input  wire logic        irq_acked,
  input  wire logic [5:0]  slave_am_in,
  output logic             slave_am_hit,
  output logic             slave_am_user,
  output logic             led_on,
  output logic             sys_reset_pulse
);
  typedef enum {ST_IDLE, ST_REQ, ST_ADDR, ST_SETUP, ST_STRB, ST_GAP, ST_END} cyc_state_type;

  cyc_state_type           st_r;
  cyc_state_type           st_nxt;
  logic [15:0]             mode_r;
  logic [15:0]             mode_nxt;
  logic                    irq_pend_r;
  logic [SYSRST_CNT_W-1:0] rst_cnt_r;
  logic                    own_r;
  logic                    half_r;
  logic                    ack_r;
  logic [31:0]             rdata_r;
  logic [27:0]             off_r;
  logic                    wr_r;
  logic [31:0]             wdata_r;
  logic [3:0]              ts_r;
  logic [5:0]              am_r;
  logic [1:0]              page_r;
  logic [31:1]             addr_r;
  logic [31:0]             dout_r;
  logic                    ds0_en_r;
  logic                    ds1_en_r;
  logic                    lw_en_r;
  logic                    take;
  logic                    reg_hit;
  logic                    win_hit;
  logic                    reg_wr;
  logic                    clr;
  xfer_kind_type           kind;
  logic                    a01;
  logic                    a00;
  logic [1:0]              lane;
  logic [31:1]             addr_c;
  logic [31:0]             dout_c;
  logic [7:0]              wbyte;
  logic [15:0]             rd_val;

  assign clr     = sys_rst || processor_reset_signal;
  assign take    = gbus_strobe && (st_r == ST_IDLE) && !ack_r;
  assign reg_hit = (gbus_addr == MODE_REG_ADDR);
  assign win_hit = (gbus_addr[31:28] == WINDOW_BASE_NIB);
  assign reg_wr  = take && reg_hit && gbus_write;
  assign rd_val  = {mode_r[15:IRQP_BIT+1], irq_pend_r, mode_r[IRQP_BIT-1:0]};

  // Status bit is never stored from a processor write
  always_comb begin
    mode_nxt           = gbus_wdata[15:0];
    mode_nxt[IRQP_BIT] = 1'b0; // R12
  end

  always_ff @(posedge clock) begin
    if (clr) begin
      mode_r <= MODE_RESET; // R20
    end else if (reg_wr) begin
      mode_r <= mode_nxt; // R7
    end
  end

  // Set wins when send and acknowledge coincide
  always_ff @(posedge clock) begin
    if (clr) begin
      irq_pend_r <= 1'b0;
    end else if (irq_sent) begin
      irq_pend_r <= 1'b1; // R12
    end else if (irq_acked) begin
      irq_pend_r <= 1'b0; // R12
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rst_cnt_r <= '0;
    end else if (reg_wr && gbus_wdata[SYSRST_BIT]) begin
      rst_cnt_r <= SYSRST_CNT_W'(SYSRST_CYCLES); // R20
    end else if (rst_cnt_r != '0) begin
      rst_cnt_r <= rst_cnt_r - 1'b1;
    end
  end

  assign sys_reset_pulse = (rst_cnt_r != '0);
  assign led_on          = mode_r[LED_BIT]; // R11

  // Mode is sampled once per access, so a rewrite only affects later cycles
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      off_r   <= '0;
      wr_r    <= 1'b0;
      wdata_r <= '0;
      ts_r    <= '0;
      am_r    <= '0;
      page_r  <= '0;
    end else if (take && win_hit) begin
      off_r   <= gbus_addr[27:0]; // R18
      wr_r    <= gbus_write;
      wdata_r <= gbus_wdata;
      ts_r    <= mode_r[TSEL_LSB+3:TSEL_LSB]; // R7
      am_r    <= mode_r[AM_LSB+5:AM_LSB]; // R13
      page_r  <= mode_r[PAGE_HI_BIT:PAGE_LO_BIT]; // R17
    end
  end

  always_comb begin
    case (ts_r[1:0])
      TS_LONG: kind = XK_LONG;
      TS_WORD: kind = ts_r[2] ? XK_WORD : XK_DOUBLE;
      TS_BYTE: kind = XK_BYTE;
      default: kind = XK_IACK;
    endcase
  end

  assign lane  = ts_r[3:2]; // R4
  assign a00   = ts_r[2];
  assign wbyte = wdata_r[8*lane +: 8];

  always_comb begin
    a01    = 1'b0;
    dout_c = '0;
    case (kind)
      XK_LONG: begin
        a01    = 1'b0; // R1
        dout_c = wdata_r; // R1
      end
      XK_DOUBLE: begin
        a01    = half_r; // R2
        dout_c = {16'h0000, half_r ? wdata_r[31:16] : wdata_r[15:0]}; // R2
      end
      XK_WORD: begin
        a01    = ts_r[3]; // R3
        dout_c = {16'h0000, ts_r[3] ? wdata_r[31:16] : wdata_r[15:0]}; // R3
      end
      XK_BYTE: begin
        a01    = ts_r[3]; // R4
        dout_c = a00 ? {16'h0000, wbyte, 8'h00} : {24'h000000, wbyte}; // R5
      end
      default: begin
        a01    = off_r[0];
        dout_c = '0;
      end
    endcase
    // Upper address from page bits, A01 from select or half, rest from window offset (IACK: offset 2..0 on A03-A01)
    if (kind == XK_IACK) begin
      addr_c = {page_r, 26'h0000000, off_r[2:0]}; // R6
    end else begin
      addr_c = {page_r, off_r, a01}; // R8 R17 R18
    end
  end

  // Address, data and strobe selects settle one cycle ahead of AS
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      addr_r   <= '0;
      dout_r   <= '0;
      ds0_en_r <= 1'b0;
      ds1_en_r <= 1'b0;
      lw_en_r  <= 1'b0;
    end else if (st_r == ST_ADDR) begin
      addr_r   <= addr_c; // R8
      dout_r   <= dout_c;
      ds0_en_r <= !(kind == XK_BYTE && a00); // R5 R8
      ds1_en_r <= !((kind == XK_BYTE && !a00) || kind == XK_IACK); // R5 R6
      lw_en_r  <= (kind == XK_LONG); // R1
    end
  end

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (take && win_hit && !reg_hit) begin
          st_nxt = own_r ? ST_ADDR : ST_REQ; // R19 R9
        end
      end
      ST_REQ: begin
        if (vme_bus_grant) begin
          st_nxt = ST_ADDR; // R21
        end
      end
      ST_ADDR:  st_nxt = ST_SETUP;
      ST_SETUP: st_nxt = ST_STRB;
      ST_STRB: begin
        if (!vme_dtack_n) begin
          st_nxt = (kind == XK_DOUBLE && !half_r) ? ST_GAP : ST_END; // R2 R14
        end
      end
      ST_GAP: begin
        if (vme_dtack_n) begin
          st_nxt = ST_ADDR; // R2
        end
      end
      ST_END: begin
        if (vme_dtack_n) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      half_r <= 1'b0;
    end else if (st_r == ST_IDLE) begin
      half_r <= 1'b0;
    end else if (st_r == ST_GAP && vme_dtack_n) begin
      half_r <= 1'b1; // R2
    end
  end

  // Ownership survives between cycles while the hold bit is set
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      own_r <= 1'b0;
    end else if (st_r == ST_REQ && vme_bus_grant) begin
      own_r <= 1'b1; // R21
    end else if (st_r == ST_END && vme_dtack_n && !mode_r[HOLD_BIT]) begin
      own_r <= 1'b0; // R21
    end else if (st_r == ST_IDLE && !mode_r[HOLD_BIT]) begin
      own_r <= 1'b0; // R9
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_r <= '0;
    end else if (take) begin
      rdata_r <= reg_hit ? {16'h0000, rd_val} : '0;
    end else if (st_r == ST_STRB && !vme_dtack_n && !wr_r) begin
      case (kind)
        XK_LONG:   rdata_r <= vme_data_in; // R1
        XK_DOUBLE: begin
          if (half_r) begin
            rdata_r[31:16] <= vme_data_in[15:0]; // R2
          end else begin
            rdata_r[15:0] <= vme_data_in[15:0]; // R2
          end
        end
        XK_WORD: begin
          if (ts_r[3]) begin
            rdata_r[31:16] <= vme_data_in[15:0]; // R3
          end else begin
            rdata_r[15:0] <= vme_data_in[15:0]; // R3
          end
        end
        XK_BYTE: begin
          for (int i = 0; i < 4; i++) begin
            if (lane == i[1:0]) begin
              rdata_r[8*i +: 8] <= a00 ? vme_data_in[15:8] : vme_data_in[7:0]; // R4 R5
            end
          end
        end
        default:   rdata_r <= {24'h000000, vme_data_in[7:0]}; // R6
      endcase
    end
  end

  // Register and unmapped accesses answer on the next edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (take && (reg_hit || !win_hit)) || (st_r == ST_END && vme_dtack_n);
    end
  end

  assign gbus_ack     = ack_r;
  assign gbus_rdata   = rdata_r;
  assign vme_bus_req  = (st_r == ST_REQ); // R21
  assign vme_bus_busy = own_r; // R9
  assign vme_addr     = addr_r;
  assign vme_am       = am_r; // R13 R14
  assign vme_addr_oe  = (st_r == ST_SETUP) || (st_r == ST_STRB);
  assign vme_as_n     = !(st_r == ST_STRB);
  assign vme_ds0_n    = !(st_r == ST_STRB && ds0_en_r); // R8
  assign vme_ds1_n    = !(st_r == ST_STRB && ds1_en_r); // R8
  assign vme_lword_n  = !(st_r == ST_STRB && lw_en_r); // R1
  assign vme_iack_n   = !(vme_addr_oe && kind == XK_IACK); // R6
  assign vme_write_n  = !(vme_addr_oe && wr_r && kind != XK_IACK);
  assign vme_data_out = dout_r;
  assign vme_data_oe  = (vme_addr_oe && wr_r && kind != XK_IACK) ?
                        {lw_en_r, 1'b1} : 2'b00;

  slave_am_decode #(
    .USER_AM_EN (1'b0)
  ) u_am_dec (
    .am_code     (slave_am_in),
    .am_hit      (slave_am_hit),
    .am_user     (slave_am_user),
    .am_reserved ()
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_LONG_CYCLE: assert property ((st_r == ST_STRB && kind == XK_LONG) |-> // R1
    !vme_ds0_n && !vme_ds1_n && !vme_lword_n && !vme_addr[1] && vme_data_oe == {2{wr_r}}
    && vme_write_n == !wr_r && vme_addr_oe)
    else $error("long cycle lines wrong");
  AST_DOUBLE_SECOND: assert property ( // R2
    (st_r == ST_STRB && kind == XK_DOUBLE && !half_r && !vme_dtack_n) |=>
    (st_r == ST_GAP) ##[1:300] (st_r == ST_STRB && half_r && vme_addr[1] && vme_lword_n))
    else $error("double cycle second half missing");
  AST_WORD_HALF: assert property ((st_r == ST_STRB && kind == XK_WORD) |-> // R3
    vme_addr[1] == ts_r[3] && vme_lword_n && !vme_ds0_n && !vme_ds1_n)
    else $error("single word address or strobes wrong");
  AST_BYTE_STROBE: assert property ((st_r == ST_STRB && kind == XK_BYTE) |-> // R5
    (vme_ds0_n != vme_ds1_n) && (vme_ds0_n == ts_r[2]) && vme_lword_n)
    else $error("byte cycle strobe wrong");
  AST_IACK_CYCLE: assert property ((st_r == ST_STRB && kind == XK_IACK) |-> // R6
    !vme_iack_n && !vme_ds0_n && vme_ds1_n && vme_addr[3:1] == off_r[2:0]
    && vme_write_n && vme_data_oe == 2'b00)
    else $error("iack cycle lines wrong");
  AST_LED_FOLLOWS: assert property ((reg_wr && !processor_reset_signal) |=> // R11
    led_on == $past(gbus_wdata[LED_BIT]))
    else $error("indicator does not follow write");
  AST_IRQ_PEND: assert property ((irq_sent && !processor_reset_signal) |=> // R12
    irq_pend_r)
    else $error("pending flag not set");
  AST_IRQ_CLEAR: assert property ((irq_acked && !irq_sent) |=> !irq_pend_r) // R12
    else $error("pending flag not cleared");
  AST_AM_PAGE: assert property ((st_r == ST_STRB) |-> // R13
    vme_am == am_r && vme_addr[31:30] == page_r && own_r)
    else $error("modifier or page lines wrong");
  AST_SLAVE_BLOCK: assert property ((slave_am_in == 6'h3F || slave_am_in == 6'h0E) |-> // R15
    !slave_am_hit)
    else $error("slave answered excluded modifier");
  AST_GRANT_FIRST: assert property ((st_r == ST_REQ && !vme_bus_grant) |=> // R21
    vme_as_n && (st_r == ST_REQ))
    else $error("cycle started without grant");
  AST_HOLD_KEEPS: assert property ((own_r && mode_r[HOLD_BIT]) |=> own_r) // R9
    else $error("ownership dropped while held");
  AST_RESET_PULSE: assert property ((reg_wr && gbus_wdata[SYSRST_BIT]) |=> // R20
    sys_reset_pulse [*8])
    else $error("reset pulse too short");

  COV_DOUBLE: cover property ((st_r == ST_END) && kind == XK_DOUBLE && half_r);
  COV_BYTE:   cover property ((st_r == ST_STRB) && kind == XK_BYTE && !vme_dtack_n);
  COV_IACK:   cover property ((st_r == ST_STRB) && kind == XK_IACK && !vme_dtack_n);
  COV_REGWR:  cover property (reg_wr ##1 gbus_ack);
endmodule : vme_master_cycle_control

// ### test/vme_far_model.sv
module vme_far_model (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        slow,
  input  wire logic [31:0] rd_val,
  input  wire logic        vme_bus_req,
  input  wire logic        vme_bus_busy,
  input  wire logic        vme_as_n,
  input  wire logic        vme_ds0_n,
  input  wire logic        vme_ds1_n,
  input  wire logic        vme_lword_n,
  input  wire logic        vme_iack_n,
  input  wire logic [31:1] vme_addr,
  input  wire logic [5:0]  vme_am,
  input  wire logic [31:0] vme_data_out,
  output logic             vme_bus_grant,
  output logic             vme_dtack_n,
  output logic      [31:0] vme_data_in,
  output int               cyc_n,
  output logic      [31:0] first_dat,
  output logic      [31:0] last_dat,
  output logic      [1:0]  last_ds,
  output logic             last_lw,
  output logic             last_iack,
  output logic      [31:1] last_a,
  output logic      [5:0]  last_am,
  output logic             bad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] wait_r;
  logic       strb;
  assign strb = !vme_as_n && !(vme_ds0_n && vme_ds1_n);
  // Inverted outside strobes so a late capture is seen
  assign vme_data_in = strb ? rd_val : ~rd_val;
  // No other master gets the bus while the owner stays busy
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      vme_bus_grant <= 1'b0;
      bad <= 1'b0;
    end else begin
      vme_bus_grant <= vme_bus_req | vme_bus_busy;
      if (!vme_as_n && !vme_bus_grant) begin
        bad <= 1'b1;
      end
    end
  end
  // Slave answers fast or slow, records each cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wait_r <= 3'h0;
      vme_dtack_n <= 1'b1;
      cyc_n <= 0;
    end else if (!strb) begin
      wait_r <= 3'h0;
      vme_dtack_n <= 1'b1;
    end else if (vme_dtack_n && wait_r != (slow ? 3'h4 : 3'h0)) begin
      wait_r <= wait_r + 3'h1;
    end else if (vme_dtack_n) begin
      vme_dtack_n <= 1'b0;
      cyc_n <= cyc_n + 1;
      first_dat <= last_dat;
      last_dat <= vme_data_out;
      last_ds <= {vme_ds1_n, vme_ds0_n};
      last_lw <= vme_lword_n;
      last_iack <= vme_iack_n;
      last_a <= vme_addr;
      last_am <= vme_am;
    end
  end
endmodule : vme_far_model

// ### test/testbench.sv
module testbench
  import vme_master_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, sys_rst, prst, strobe, wr, ack, req, grant, busy, oe_a;
  logic        as_n, ds0_n, ds1_n, lw_n, wr_n, iack_n, dtack_n, irq_s, irq_a;
  logic        am_hit, am_user, led, srp, slow, lw, iack, bad;
  logic [31:0] addr, wdata, rdata, vdin, vdout, rd_val, fdat, ldat;
  logic [31:1] vaddr, la;
  logic [5:0]  vam, sam, lam;
  logic [1:0]  doe, lds;
  int          cyc_n, n_mismatch, n_checks, tick;
  logic [3:0]  sels [9] = '{4'h0, 4'hC, 4'h1, 4'h5, 4'hD, 4'h2, 4'h6, 4'hA, 4'hE};
  logic [5:0]  ams [9] = '{6'h3F, 6'h3B, 6'h0F, 6'h0B, 6'h09, 6'h0D, 6'h39, 6'h2D, 6'h3E};

  vme_master_cycle_control vme_master_cycle_control_i (
    .clock(clock), .sys_rst(sys_rst), .processor_reset_signal(prst),
    .gbus_addr(addr), .gbus_wdata(wdata), .gbus_strobe(strobe), .gbus_write(wr),
    .gbus_rdata(rdata), .gbus_ack(ack), .vme_bus_req(req), .vme_bus_grant(grant),
    .vme_bus_busy(busy), .vme_addr(vaddr), .vme_am(vam), .vme_addr_oe(oe_a),
    .vme_as_n(as_n), .vme_ds0_n(ds0_n), .vme_ds1_n(ds1_n), .vme_lword_n(lw_n),
    .vme_write_n(wr_n), .vme_iack_n(iack_n), .vme_dtack_n(dtack_n),
    .vme_data_in(vdin), .vme_data_out(vdout), .vme_data_oe(doe), .irq_sent(irq_s),
    .irq_acked(irq_a), .slave_am_in(sam), .slave_am_hit(am_hit),
    .slave_am_user(am_user), .led_on(led), .sys_reset_pulse(srp));

  vme_far_model vme_far_model_i (
    .clock(clock), .sys_rst(sys_rst), .slow(slow), .rd_val(rd_val),
    .vme_bus_req(req), .vme_bus_busy(busy), .vme_as_n(as_n), .vme_ds0_n(ds0_n),
    .vme_ds1_n(ds1_n), .vme_lword_n(lw_n), .vme_iack_n(iack_n), .vme_addr(vaddr),
    .vme_am(vam), .vme_data_out(vdout), .vme_bus_grant(grant), .vme_dtack_n(dtack_n),
    .vme_data_in(vdin), .cyc_n(cyc_n), .first_dat(fdat), .last_dat(ldat),
    .last_ds(lds), .last_lw(lw), .last_iack(iack), .last_a(la), .last_am(lam),
    .bad(bad));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk

  // Request held until the edge that samples ack, dropped after it
  task automatic acc(input logic [31:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clock) #5;
    addr = a;
    wr = w;
    wdata = d;
    strobe = 1'b1;
    k = 0;
    while (ack !== 1'b1 && k < 300) begin
      @(posedge clock) #5;
      k++;
    end
    chk(ack, 1'b1, "no answer");
    @(posedge clock) #5;
    strobe = 1'b0;
  endtask : acc

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask : wait_cyc

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Whole run needs about 4400 cycles
  always @(posedge clock) begin
    tick++;
    if (tick == 40000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    logic [3:0]  sel;
    logic [27:0] idx;
    logic        dbl;
    logic        a01;
    int          base;
    logic [31:0] exp_rd;
    sys_rst = 1'b1;
    prst = 1'b0;
    strobe = 1'b0;
    wr = 1'b0;
    addr = 32'h0;
    wdata = 32'h0;
    irq_s = 1'b0;
    irq_a = 1'b0;
    sam = 6'h00;
    slow = 1'b0;
    rd_val = 32'h0;
    wait_cyc(3);
    sys_rst = 1'b0;
    acc(MODE_REG_ADDR, 1'b0, 32'h0);
    chk(rdata, {16'h0000, MODE_RESET}, "reset value");
    acc(MODE_REG_ADDR, 1'b1, 32'h0000_ABCC);
    chk(led, 1'b1, "led on");
    acc(MODE_REG_ADDR, 1'b0, 32'h0);
    chk(rdata, 32'h0000_AB4C, "status write");
    irq_s = 1'b1;
    wait_cyc(1);
    irq_s = 1'b0;
    acc(MODE_REG_ADDR, 1'b0, 32'h0);
    chk(rdata, 32'h0000_ABCC, "pending set");
    irq_a = 1'b1;
    wait_cyc(1);
    irq_a = 1'b0;
    acc(MODE_REG_ADDR, 1'b0, 32'h0);
    chk(rdata, 32'h0000_AB4C, "pending clear");
    acc(32'h1000_0000, 1'b0, 32'h0);
    chk(rdata, 32'h0, "unmapped");
    $display("test registers done");
    for (int c = 0; c < 64; c++) begin
      sam = c[5:0];
      wait_cyc(1);
      chk(am_hit, c inside {'h3E, 'h3D, 'h3A, 'h39, 'h2D, 'h29, 'h0D, 'h09}, "hit");
      chk(am_user, c inside {[16:31]}, "user code");
    end
    $display("test slave modifier done");
    rd_val = 32'h5A69_F01E;
    for (int i = 0; i < 9; i++) begin
      sel = sels[i];
      idx = 28'h0123450 + i;
      acc(MODE_REG_ADDR, 1'b1, {16'h0000, i[1:0], ams[i], 3'h0, sel, 1'b0});
      slow = i[0];
      base = cyc_n;
      acc({WINDOW_BASE_NIB, idx}, 1'b1, 32'hA1B2_C3D4);
      dbl = (sel[2:0] == 3'h1);
      a01 = (sel[1:0] == TS_LONG) ? 1'b0 : (dbl | sel[3]);
      chk(cyc_n - base, dbl ? 2 : 1, "cycle count");
      chk(la, {i[1:0], idx, a01}, "address");
      chk(lam, ams[i], "modifier");
      chk(lw, sel[1:0] != TS_LONG, "lword");
      chk(lds, (sel[1:0] == TS_BYTE) ? {~sel[2], sel[2]} : 2'b00, "strobes");
      if (sel[1:0] == TS_LONG) begin
        chk(ldat, 32'hA1B2_C3D4, "long data");
      end else if (sel[1:0] == TS_BYTE) begin
        chk(ldat[8*sel[2] +: 8], (32'hA1B2_C3D4 >> (8*sel[3:2])) & 32'hFF, "byte lane");
      end else begin
        chk(ldat[15:0], (32'hA1B2_C3D4 >> (16*(dbl | sel[3]))) & 32'hFFFF, "word half");
      end
      if (dbl) begin
        chk(fdat[15:0], 16'hC3D4, "first half");
      end
      // Read back through the same mode to reach every capture lane
      acc({WINDOW_BASE_NIB, idx}, 1'b0, 32'h0);
      if (sel[1:0] == TS_LONG) begin
        exp_rd = rd_val;
      end else if (sel[1:0] == TS_BYTE) begin
        exp_rd = 32'(rd_val[8*sel[2] +: 8]) << (8*sel[3:2]);
      end else begin
        exp_rd = dbl ? {2{rd_val[15:0]}} : 32'(rd_val[15:0]) << (16*sel[3]);
      end
      chk(rdata, exp_rd, "read lanes");
    end
    chk(led, 1'b0, "led off");
    $display("test transfer modes done");
    acc(MODE_REG_ADDR, 1'b1, 32'h0000_2906);
    rd_val = 32'hC3C3_3CA5;
    acc(32'hB000_0005, 1'b0, 32'h0);
    chk(rdata[7:0], 8'hA5, "vector");
    chk({lds, iack, la[3:1]}, {2'b10, 1'b0, 3'h5}, "iack cycle");
    // Hold bit set before the bus is requested
    acc(MODE_REG_ADDR, 1'b1, 32'h0000_0920);
    rd_val = 32'h1357_9BDF;
    acc(32'hB000_0040, 1'b0, 32'h0);
    chk(rdata, 32'h1357_9BDF, "long read");
    wait_cyc(4);
    chk(busy, 1'b1, "bus held");
    acc(32'hB000_0044, 1'b0, 32'h0);
    chk({lds, lw, lam}, {3'b000, 6'h09}, "mode kept");
    acc(MODE_REG_ADDR, 1'b1, 32'h0000_0900);
    wait_cyc(4);
    chk(busy, 1'b0, "bus released");
    chk(bad, 1'b0, "drive without grant");
    $display("test iack and hold done");
    acc(MODE_REG_ADDR, 1'b1, 32'h0000_0001);
    chk(srp, 1'b1, "pulse fired");
    wait_cyc(SYSRST_CYCLES - 8);
    chk(srp, 1'b1, "pulse width");
    wait_cyc(16);
    chk(srp, 1'b0, "pulse over");
    acc(MODE_REG_ADDR, 1'b1, 32'h0000_C040);
    prst = 1'b1;
    wait_cyc(1);
    prst = 1'b0;
    acc(MODE_REG_ADDR, 1'b0, 32'h0);
    chk(rdata, 32'h0, "processor reset");
    chk(led, 1'b0, "led cleared");
    $display("test resets done");
    wrap_up();
  end
endmodule : testbench
